// >>> hdl/vr_regs_pkg.sv
// Register indices, reset values, codes and types of the voltage control register set
package vr_regs_pkg;

  // Register indices on the serial command port
  localparam logic [7:0] IDX_BOOT_VOLTAGE = 8'h26;
  localparam logic [7:0] IDX_MAX_LIMIT = 8'h30;
  localparam logic [7:0] IDX_TARGET_CODE = 8'h31;
  localparam logic [7:0] IDX_POWER_STATE = 8'h32;
  localparam logic [7:0] IDX_MARGIN_OFFSET = 8'h33;
  localparam logic [7:0] IDX_MULTI_CFG = 8'h34;

  // Values after reset
  localparam logic [7:0] BOOT_VOLTAGE_RST = 8'h00;
  localparam logic [7:0] MAX_LIMIT_RST = 8'hfb;
  localparam logic [7:0] TARGET_CODE_RST = 8'h00;
  localparam logic [7:0] POWER_STATE_RST = 8'h00;
  localparam logic [7:0] MARGIN_OFFSET_RST = 8'h00;
  localparam logic [7:0] MULTI_CFG_FIRST_RST = 8'h00;
  localparam logic [7:0] MULTI_CFG_SECOND_RST = 8'h01;

  // Margin offset field layout
  localparam int MARGIN_SIGN_BIT = 7;
  localparam int MARGIN_MAG_MSB = 6;

  // Power state codes forced by the power state pin
  localparam logic [7:0] INTERMEDIATE_LOW_POWER_STATE = 8'h01;
  localparam logic [7:0] DEEPEST_LOW_POWER_STATE = 8'h02;

  // Output select code meaning "follow the register setting"
  localparam logic [1:0] OUTPUT_SELECT_REGISTER = 2'h0;

  // Settle count that ends strap capture after reset: covers the two synchroniser stages
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    CMD_SET_VOLTAGE,
    CMD_SET_POWER_STATE,
    CMD_GET_REG,
    CMD_SET_REG
  } cmd_e;

  typedef enum logic [1:0] {
    RSP_ACK,
    RSP_NOT_SUPPORTED,
    RSP_REJECTED
  } rsp_e;

  typedef enum logic [1:0] {
    ST_CAPTURE,
    ST_BOOT_HOLD,
    ST_TRACK
  } vr_state_e;

endpackage

// >>> hdl/vr_margin_if.sv
// Interface carrying the target code and margin offset to the margin adder
`timescale 1ns/1ps
`default_nettype none
interface vr_margin_if;
  logic [7:0] base_code;
  logic [7:0] offset;
  logic [7:0] margined_code;
  logic saturated;
  modport calc (input base_code, input offset, output margined_code, output saturated);
  modport owner (output base_code, output offset, input margined_code, input saturated);
endinterface
`default_nettype wire

// >>> hdl/vr_margin_adder.sv
// Sign-magnitude margin adder with saturation at the code range ends
`timescale 1ns/1ps
`default_nettype none
module vr_margin_adder (
  vr_margin_if.calc mif
);
  import vr_regs_pkg::*;

  logic [8:0] base_wide;
  logic [8:0] mag_wide;
  logic [8:0] sum_wide;

  // sign and magnitude
  // Widen by one bit so carry and borrow are visible before saturating
  always_comb begin
    base_wide = {1'b0, mif.base_code};
    mag_wide = {2'b00, mif.offset[MARGIN_MAG_MSB:0]};
    sum_wide = 9'h000;
    mif.margined_code = mif.base_code;
    mif.saturated = 1'b0;
    if (mif.offset[MARGIN_SIGN_BIT]) begin
      if (base_wide < mag_wide) begin
        mif.margined_code = 8'h00;
        mif.saturated = 1'b1;
      end else begin
        sum_wide = base_wide - mag_wide;
        mif.margined_code = sum_wide[7:0];
      end
    end else begin
      sum_wide = base_wide + mag_wide;
      if (sum_wide[8]) begin
        mif.margined_code = 8'hff;
        mif.saturated = 1'b1;
      end else begin
        mif.margined_code = sum_wide[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/vr_pin_override.sv
// Synchronisers and decode for the output select and power state pins
`timescale 1ns/1ps
`default_nettype none
module vr_pin_override (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic output_select_a,
  input wire logic output_select_b,
  input wire logic power_state_pin_high,
  input wire logic power_state_pin_open,
  output logic [1:0] select_code,
  output logic ps_override,
  output logic [7:0] ps_forced_code
);
  import vr_regs_pkg::*;

  logic [3:0] pins_meta_reg;
  logic [3:0] pins_sync_reg;

  // Two-stage synchroniser; only the second stage is decoded
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pins_meta_reg <= 4'h0;
      pins_sync_reg <= 4'h0;
    end else if (clk_en) begin
      pins_meta_reg <= {power_state_pin_open, power_state_pin_high, output_select_b, output_select_a};
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // Pin decode; a driven-high reading wins over the open-pin detector
  always_comb begin
    select_code = pins_sync_reg[1:0];
    ps_override = pins_sync_reg[2] | pins_sync_reg[3];
    if (pins_sync_reg[2]) begin
      ps_forced_code = DEEPEST_LOW_POWER_STATE;
    end else if (pins_sync_reg[3]) begin
      ps_forced_code = INTERMEDIATE_LOW_POWER_STATE;
    end else begin
      ps_forced_code = POWER_STATE_RST;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/vr_voltage_control_registers.sv
// Voltage control register set: boot hold, limit check, target, power state, margin, multi-regulator config
//
// Operation
// - With boot voltage programmed, output holds boot level until a set-voltage command within the limit arrives.
// - Set-voltage codes above the maximum limit get a not-supported reply, not applied.
// - Target voltage code register holds the programmed target, resets to 00h.
// - Power state register holds the last power state programmed, resets to 00h.
// - Margin offset in VID steps is added to the target; zero means no margin.
// - Offset lower seven bits are the margin magnitude in VID steps.
// - Multi-regulator config resets to 00h on first regulator, 01h on second.
// - Both output select pins low: follow registers; otherwise pin-selected fixed voltage.
// - Power state pin: low uses register, high deepest, open intermediate state.
`timescale 1ns/1ps
`default_nettype none
module vr_voltage_control_registers (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] boot_voltage_strap,
  input wire logic second_regulator_strap,
  input wire logic output_select_a,
  input wire logic output_select_b,
  input wire logic power_state_pin_high,
  input wire logic power_state_pin_open,
  input wire logic cmd_valid,
  input wire vr_regs_pkg::cmd_e cmd_kind,
  input wire logic [7:0] cmd_index,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output vr_regs_pkg::rsp_e rsp_code,
  output logic [7:0] rsp_data,
  output logic [7:0] vout_code,
  output logic pin_override,
  output logic [1:0] pin_select,
  output logic [7:0] effective_power_state,
  output logic boot_hold
);
  import vr_regs_pkg::*;

  vr_state_e state_reg;
  logic [1:0] settle_reg;
  logic boot_hold_reg;
  logic [7:0] boot_meta_reg;
  logic [7:0] boot_sync_reg;
  logic second_meta_reg;
  logic second_sync_reg;
  logic [7:0] boot_voltage_reg;
  logic [7:0] max_limit_reg;
  logic [7:0] target_code_reg;
  logic [7:0] power_state_reg;
  logic [7:0] margin_offset_reg;
  logic [7:0] multi_cfg_reg;
  logic rsp_valid_reg;
  rsp_e rsp_code_reg;
  logic [7:0] rsp_data_reg;
  logic [7:0] vout_code_reg;
  logic pin_override_reg;
  logic [1:0] pin_select_reg;
  logic [7:0] effective_ps_reg;
  logic [1:0] select_code;
  logic ps_override;
  logic [7:0] ps_forced_code;
  logic cmd_take;
  logic over_limit;
  logic set_voltage_ok;

  vr_margin_if mif ();

  vr_margin_adder u_margin (
    .mif(mif.calc)
  );

  vr_pin_override u_pins (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .output_select_a(output_select_a),
    .output_select_b(output_select_b),
    .power_state_pin_high(power_state_pin_high),
    .power_state_pin_open(power_state_pin_open),
    .select_code(select_code),
    .ps_override(ps_override),
    .ps_forced_code(ps_forced_code)
  );

  // Registers software may write; target and power state move only by command
  function automatic logic is_writable(input logic [7:0] idx);
    is_writable = (idx == IDX_BOOT_VOLTAGE) || (idx == IDX_MAX_LIMIT) ||
                  (idx == IDX_MARGIN_OFFSET) || (idx == IDX_MULTI_CFG);
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = is_writable(idx) || (idx == IDX_TARGET_CODE) || (idx == IDX_POWER_STATE);
  endfunction

  // Feed the margin adder from the live registers
  assign mif.base_code = target_code_reg;
  assign mif.offset = margin_offset_reg;

  // Commands are refused while straps are still being captured
  assign cmd_take = cmd_valid && clk_en && (state_reg != ST_CAPTURE);
  assign over_limit = cmd_data > max_limit_reg;
  assign set_voltage_ok = cmd_take && (cmd_kind == CMD_SET_VOLTAGE) && !over_limit;

  // Strap synchronisers: pins are not on the core clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      boot_meta_reg <= 8'h00;
      boot_sync_reg <= 8'h00;
      second_meta_reg <= 1'b0;
      second_sync_reg <= 1'b0;
    end else if (clk_en) begin
      boot_meta_reg <= boot_voltage_strap;
      boot_sync_reg <= boot_meta_reg;
      second_meta_reg <= second_regulator_strap;
      second_sync_reg <= second_meta_reg;
    end
  end

  // Sequencing: capture straps, hold boot level, then track commanded target
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_CAPTURE;
      settle_reg <= 2'h0;
      boot_hold_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        ST_CAPTURE: begin
          if (settle_reg == STRAP_SETTLE_CYCLES) begin
            state_reg <= ST_BOOT_HOLD;
            boot_hold_reg <= 1'b1;
          end else begin
            settle_reg <= settle_reg + 2'h1;
          end
        end
        ST_BOOT_HOLD: begin
          if (set_voltage_ok) begin
            state_reg <= ST_TRACK;
            boot_hold_reg <= 1'b0;
          end
        end
        ST_TRACK: begin
          state_reg <= ST_TRACK;
        end
        default: begin
          state_reg <= ST_CAPTURE;
          boot_hold_reg <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers; straps are loaded on leaving capture, after synchronising
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      boot_voltage_reg <= BOOT_VOLTAGE_RST;
      max_limit_reg <= MAX_LIMIT_RST;
      margin_offset_reg <= MARGIN_OFFSET_RST;
      multi_cfg_reg <= MULTI_CFG_FIRST_RST;
    end else if (clk_en) begin
      if (state_reg == ST_CAPTURE && settle_reg == STRAP_SETTLE_CYCLES) begin
        boot_voltage_reg <= boot_sync_reg;
        multi_cfg_reg <= second_sync_reg ? MULTI_CFG_SECOND_RST : MULTI_CFG_FIRST_RST;
      end else if (cmd_take && cmd_kind == CMD_SET_REG) begin
        case (cmd_index)
          IDX_BOOT_VOLTAGE: boot_voltage_reg <= cmd_data;
          IDX_MAX_LIMIT: max_limit_reg <= cmd_data;
          IDX_MARGIN_OFFSET: margin_offset_reg <= cmd_data;
          IDX_MULTI_CFG: multi_cfg_reg <= cmd_data;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      target_code_reg <= TARGET_CODE_RST;
    end else if (set_voltage_ok) begin
      target_code_reg <= cmd_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      power_state_reg <= POWER_STATE_RST;
    end else if (cmd_take && cmd_kind == CMD_SET_POWER_STATE) begin
      power_state_reg <= cmd_data;
    end
  end

  // Replies: one cycle after the command is taken
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_code_reg <= RSP_ACK;
      rsp_data_reg <= 8'h00;
    end else if (clk_en) begin
      rsp_valid_reg <= cmd_valid;
      rsp_data_reg <= 8'h00;
      rsp_code_reg <= RSP_ACK;
      if (state_reg == ST_CAPTURE) begin
        rsp_code_reg <= RSP_REJECTED;
      end else begin
        case (cmd_kind)
          CMD_SET_VOLTAGE: begin
            if (over_limit) begin
              rsp_code_reg <= RSP_NOT_SUPPORTED;
            end
          end
          CMD_SET_POWER_STATE: rsp_code_reg <= RSP_ACK;
          CMD_GET_REG: begin
            if (!is_mapped(cmd_index)) begin
              rsp_code_reg <= RSP_REJECTED;
            end
            case (cmd_index)
              IDX_BOOT_VOLTAGE: rsp_data_reg <= boot_voltage_reg;
              IDX_MAX_LIMIT: rsp_data_reg <= max_limit_reg;
              IDX_TARGET_CODE: rsp_data_reg <= target_code_reg;
              IDX_POWER_STATE: rsp_data_reg <= power_state_reg;
              IDX_MARGIN_OFFSET: rsp_data_reg <= margin_offset_reg;
              IDX_MULTI_CFG: rsp_data_reg <= multi_cfg_reg;
              default: rsp_data_reg <= 8'h00;
            endcase
          end
          CMD_SET_REG: begin
            if (!is_writable(cmd_index)) begin
              rsp_code_reg <= RSP_REJECTED;
            end
          end
          default: rsp_code_reg <= RSP_REJECTED;
        endcase
      end
    end
  end

  // Output target: boot level while holding, margined target afterwards
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      vout_code_reg <= 8'h00;
    end else if (clk_en) begin
      case (state_reg)
        ST_BOOT_HOLD: vout_code_reg <= boot_voltage_reg;
        ST_TRACK: vout_code_reg <= mif.margined_code;
        default: vout_code_reg <= 8'h00;
      endcase
    end
  end

  // Pin overrides; the analog side maps the select code to a fixed voltage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_override_reg <= 1'b0;
      pin_select_reg <= OUTPUT_SELECT_REGISTER;
      effective_ps_reg <= POWER_STATE_RST;
    end else if (clk_en) begin
      pin_override_reg <= select_code != OUTPUT_SELECT_REGISTER;
      pin_select_reg <= select_code;
      effective_ps_reg <= ps_override ? ps_forced_code : power_state_reg;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_code = rsp_code_reg;
  assign rsp_data = rsp_data_reg;
  assign vout_code = vout_code_reg;
  assign pin_override = pin_override_reg;
  assign pin_select = pin_select_reg;
  assign effective_power_state = effective_ps_reg;
  // Own flop mirrors the boot hold state so the output carries no decode logic
  assign boot_hold = boot_hold_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_limit_reply;
    cmd_take && cmd_kind == CMD_SET_VOLTAGE && cmd_data > max_limit_reg |=> rsp_valid && rsp_code == RSP_NOT_SUPPORTED;
  endproperty
  a_limit_reply: assert property (p_limit_reply) else $error("over-limit code not refused");

  property p_reject_keeps_target;
    cmd_take && cmd_kind == CMD_SET_VOLTAGE && over_limit |=> $stable(target_code_reg) && $stable(state_reg);
  endproperty
  a_reject_keeps_target: assert property (p_reject_keeps_target) else $error("refused code changed target");

  property p_target_loaded;
    set_voltage_ok |=> target_code_reg == $past(cmd_data) && rsp_code == RSP_ACK;
  endproperty
  a_target_loaded: assert property (p_target_loaded) else $error("accepted code not stored");

  property p_power_state_loaded;
    cmd_take && cmd_kind == CMD_SET_POWER_STATE |=> power_state_reg == $past(cmd_data);
  endproperty
  a_power_state_loaded: assert property (p_power_state_loaded) else $error("power state not stored");

  property p_boot_hold;
    state_reg == ST_BOOT_HOLD && clk_en && !set_voltage_ok |=> vout_code == $past(boot_voltage_reg) && boot_hold;
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot level not held");

  property p_no_margin;
    state_reg == ST_TRACK && clk_en && margin_offset_reg == 8'h00 |=> vout_code == $past(target_code_reg);
  endproperty
  a_no_margin: assert property (p_no_margin) else $error("zero offset changed output");

  property p_negative_margin;
    state_reg == ST_TRACK && clk_en && margin_offset_reg[MARGIN_SIGN_BIT] &&
      {1'b0, target_code_reg} >= {2'b00, margin_offset_reg[MARGIN_MAG_MSB:0]}
      |=> vout_code == $past(target_code_reg) - {1'b0, $past(margin_offset_reg[MARGIN_MAG_MSB:0])};
  endproperty
  a_negative_margin: assert property (p_negative_margin) else $error("negative margin wrong");

  property p_positive_margin;
    state_reg == ST_TRACK && clk_en && !margin_offset_reg[MARGIN_SIGN_BIT] &&
      {1'b0, target_code_reg} + {2'b00, margin_offset_reg[MARGIN_MAG_MSB:0]} <= 9'h0ff
      |=> vout_code == $past(target_code_reg) + {1'b0, $past(margin_offset_reg[MARGIN_MAG_MSB:0])};
  endproperty
  a_positive_margin: assert property (p_positive_margin) else $error("positive margin wrong");

  property p_multi_cfg_default;
    state_reg == ST_CAPTURE && settle_reg == STRAP_SETTLE_CYCLES && clk_en
      |=> multi_cfg_reg == ($past(second_sync_reg) ? MULTI_CFG_SECOND_RST : MULTI_CFG_FIRST_RST);
  endproperty
  a_multi_cfg_default: assert property (p_multi_cfg_default) else $error("multi config default wrong");

  property p_select_override;
    clk_en && select_code != OUTPUT_SELECT_REGISTER |=> pin_override && pin_select == $past(select_code);
  endproperty
  a_select_override: assert property (p_select_override) else $error("select pins not honoured");

  property p_ps_pin;
    clk_en && ps_override |=> effective_power_state == $past(ps_forced_code) &&
      effective_power_state != POWER_STATE_RST;
  endproperty
  a_ps_pin: assert property (p_ps_pin) else $error("power state pin not honoured");

  c_not_supported: cover property (rsp_valid && rsp_code == RSP_NOT_SUPPORTED);
  c_leave_boot: cover property (state_reg == ST_BOOT_HOLD ##1 state_reg == ST_TRACK);
  c_negative_margin: cover property (state_reg == ST_TRACK && margin_offset_reg[MARGIN_SIGN_BIT] && mif.saturated);
  c_pin_override: cover property (pin_override && effective_power_state == DEEPEST_LOW_POWER_STATE);
endmodule
`default_nettype wire

// >>> sim/cpu_cmd_master.sv
// Command port master standing in for the bus controller that issues register commands
`timescale 1ns/1ps
`default_nettype none
module cpu_cmd_master (
  input wire logic core_clk,
  output var logic cmd_valid,
  output var vr_regs_pkg::cmd_e cmd_kind,
  output var logic [7:0] cmd_index,
  output var logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire vr_regs_pkg::rsp_e rsp_code,
  input wire logic [7:0] rsp_data
);
  import vr_regs_pkg::*;

  // Idle values at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_kind = CMD_GET_REG;
    cmd_index = 8'h00;
    cmd_data = 8'h00;
  end

  // One command per call: driven after a falling edge, taken at the next rising edge,
  // and the registered answer is picked up half a cycle after that edge
  task automatic send(input cmd_e kind, input logic [7:0] index, input logic [7:0] data,
                      output logic seen, output rsp_e code, output logic [7:0] rdata);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_kind = kind;
    cmd_index = index;
    cmd_data = data;
    @(negedge core_clk);
    seen = rsp_valid;
    code = rsp_code;
    rdata = rsp_data;
    cmd_valid = 1'b0;
    // Stale bytes are inverted so a design that latches late cannot match by luck
    cmd_index = ~index;
    cmd_data = ~data;
  endtask
endmodule
`default_nettype wire

// >>> sim/vr_voltage_control_registers_tb.sv
// Self-checking bench for the voltage control register set
`timescale 1ns/1ps
`default_nettype none
module vr_voltage_control_registers_tb;
  import vr_regs_pkg::*;
  logic core_clk, sys_rst, clk_en, second_regulator_strap;
  logic output_select_a, output_select_b, power_state_pin_high, power_state_pin_open;
  logic [7:0] boot_voltage_strap, cmd_index, cmd_data, rsp_data, vout_code, effective_power_state;
  logic cmd_valid, rsp_valid, pin_override, boot_hold;
  logic [1:0] pin_select;
  cmd_e cmd_kind;
  rsp_e rsp_code;
  int bad_count = 0;
  int comparisons = 0;
  logic fz_seen;
  rsp_e fz_code;
  logic [7:0] fz_data;
  logic [7:0] ridx [6] = '{IDX_BOOT_VOLTAGE, IDX_MAX_LIMIT, IDX_TARGET_CODE, IDX_POWER_STATE,
                           IDX_MARGIN_OFFSET, IDX_MULTI_CFG};
  logic [7:0] rval [6] = '{8'h5a, MAX_LIMIT_RST, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mofs [5] = '{8'h02, 8'h81, 8'h00, 8'h7f, 8'hff};
  logic [7:0] mtgt [5] = '{8'h80, 8'h80, 8'h80, 8'hfb, 8'h10};
  logic [7:0] mexp [5] = '{8'h82, 8'h7f, 8'h80, 8'hff, 8'h00};
  logic psh [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic pso [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] pse [4] = '{DEEPEST_LOW_POWER_STATE, INTERMEDIATE_LOW_POWER_STATE, DEEPEST_LOW_POWER_STATE, 8'h03};

  vr_voltage_control_registers vr_voltage_control_registers_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .boot_voltage_strap(boot_voltage_strap), .second_regulator_strap(second_regulator_strap),
    .output_select_a(output_select_a), .output_select_b(output_select_b),
    .power_state_pin_high(power_state_pin_high), .power_state_pin_open(power_state_pin_open),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_index(cmd_index), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data), .vout_code(vout_code),
    .pin_override(pin_override), .pin_select(pin_select),
    .effective_power_state(effective_power_state), .boot_hold(boot_hold)
  );

  cpu_cmd_master cpu_cmd_master_inst (
    .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_index(cmd_index),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data)
  );

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Single comparison point; case inequality keeps unknowns from matching
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One command through the master, with its answer compared
  task automatic issue(input cmd_e kind, input logic [7:0] index, input logic [7:0] data,
                       input rsp_e exp_code, input logic [7:0] exp_data);
    logic seen;
    rsp_e code;
    logic [7:0] rdata;
    cpu_cmd_master_inst.send(kind, index, data, seen, code, rdata);
    check("rsp_valid", {7'h00, seen}, 8'h01);
    check("rsp_code", {6'h00, code}, {6'h00, exp_code});
    check("rsp_data", rdata, exp_data);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Reset for twenty cycles with the given straps; released on a falling edge
  task automatic do_reset(input logic [7:0] strap, input logic second);
    @(negedge core_clk);
    sys_rst = 1'b1;
    boot_voltage_strap = strap;
    second_regulator_strap = second;
    wait_cycles(20);
    check("vout_code in reset", vout_code, 8'h00);
    check("rsp_valid in reset", {7'h00, rsp_valid}, 8'h00);
    sys_rst = 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang is cut short far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    bad_count++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    boot_voltage_strap = 8'h5a;
    second_regulator_strap = 1'b0;
    output_select_a = 1'b0;
    output_select_b = 1'b0;
    power_state_pin_high = 1'b0;
    power_state_pin_open = 1'b0;
    do_reset(8'h5a, 1'b0);
    // Second edge after release still belongs to strap capture
    issue(CMD_SET_VOLTAGE, 8'h00, 8'h20, RSP_REJECTED, 8'h00);
    // Values after reset, boot voltage taken from the straps
    for (int i = 0; i < 6; i++) begin
      issue(CMD_GET_REG, ridx[i], 8'h00, RSP_ACK, rval[i]);
    end
    check("boot_hold", {7'h00, boot_hold}, 8'h01);
    check("vout boot", vout_code, 8'h5a);
    // One above the default limit is refused and leaves boot hold alone
    issue(CMD_SET_VOLTAGE, 8'h00, 8'hfc, RSP_NOT_SUPPORTED, 8'h00);
    wait_cycles(1);
    check("boot_hold kept", {7'h00, boot_hold}, 8'h01);
    check("vout boot kept", vout_code, 8'h5a);
    issue(CMD_GET_REG, IDX_TARGET_CODE, 8'h00, RSP_ACK, 8'h00);
    // Exactly the limit is accepted and ends boot hold
    issue(CMD_SET_VOLTAGE, 8'h00, 8'hfb, RSP_ACK, 8'h00);
    wait_cycles(1);
    check("boot_hold left", {7'h00, boot_hold}, 8'h00);
    check("vout at limit", vout_code, 8'hfb);
    // Margin sign and magnitude, including both saturation ends
    for (int i = 0; i < 5; i++) begin
      issue(CMD_SET_REG, IDX_MARGIN_OFFSET, mofs[i], RSP_ACK, 8'h00);
      issue(CMD_SET_VOLTAGE, 8'h00, mtgt[i], RSP_ACK, 8'h00);
      wait_cycles(1);
      check("vout margined", vout_code, mexp[i]);
      issue(CMD_GET_REG, IDX_MARGIN_OFFSET, 8'h00, RSP_ACK, mofs[i]);
    end
    issue(CMD_SET_REG, IDX_MARGIN_OFFSET, 8'h00, RSP_ACK, 8'h00);
    // Lowered limit: one above refused, target kept; the limit itself taken
    issue(CMD_SET_REG, IDX_MAX_LIMIT, 8'h40, RSP_ACK, 8'h00);
    issue(CMD_GET_REG, IDX_MAX_LIMIT, 8'h00, RSP_ACK, 8'h40);
    issue(CMD_SET_VOLTAGE, 8'h00, 8'h41, RSP_NOT_SUPPORTED, 8'h00);
    issue(CMD_GET_REG, IDX_TARGET_CODE, 8'h00, RSP_ACK, 8'h10);
    issue(CMD_SET_VOLTAGE, 8'h00, 8'h40, RSP_ACK, 8'h00);
    issue(CMD_GET_REG, IDX_TARGET_CODE, 8'h00, RSP_ACK, 8'h40);
    // Clock enable low freezes the port: a command is neither taken nor answered
    wait_cycles(1);
    clk_en = 1'b0;
    cpu_cmd_master_inst.send(CMD_SET_VOLTAGE, 8'h00, 8'h20, fz_seen, fz_code, fz_data);
    check("rsp_valid frozen", {7'h00, fz_seen}, 8'h00);
    check("vout frozen", vout_code, 8'h40);
    clk_en = 1'b1;
    issue(CMD_GET_REG, IDX_TARGET_CODE, 8'h00, RSP_ACK, 8'h40);
    // Power state from the bus, then every pin override reading
    issue(CMD_SET_POWER_STATE, 8'h00, 8'h03, RSP_ACK, 8'h00);
    issue(CMD_GET_REG, IDX_POWER_STATE, 8'h00, RSP_ACK, 8'h03);
    for (int i = 0; i < 4; i++) begin
      power_state_pin_high = psh[i];
      power_state_pin_open = pso[i];
      wait_cycles(3);
      check("effective_power_state", effective_power_state, pse[i]);
    end
    // Every output select code; the bus target stays in place underneath
    for (int i = 0; i < 4; i++) begin
      output_select_a = i[0];
      output_select_b = i[1];
      wait_cycles(3);
      check("pin_select", {6'h00, pin_select}, 8'(i));
      check("pin_override", {7'h00, pin_override}, {7'h00, i != 0});
      check("vout under pins", vout_code, 8'h40);
    end
    // Read-only places, unmapped places
    issue(CMD_SET_REG, IDX_TARGET_CODE, 8'h55, RSP_REJECTED, 8'h00);
    issue(CMD_SET_REG, IDX_POWER_STATE, 8'h55, RSP_REJECTED, 8'h00);
    issue(CMD_SET_REG, 8'h27, 8'h55, RSP_REJECTED, 8'h00);
    issue(CMD_GET_REG, 8'h40, 8'h00, RSP_REJECTED, 8'h00);
    issue(CMD_GET_REG, IDX_TARGET_CODE, 8'h00, RSP_ACK, 8'h40);
    issue(CMD_GET_REG, IDX_POWER_STATE, 8'h00, RSP_ACK, 8'h03);
    // Writable boot voltage and multi-regulator config
    issue(CMD_SET_REG, IDX_BOOT_VOLTAGE, 8'h33, RSP_ACK, 8'h00);
    issue(CMD_GET_REG, IDX_BOOT_VOLTAGE, 8'h00, RSP_ACK, 8'h33);
    issue(CMD_SET_REG, IDX_MULTI_CFG, 8'h05, RSP_ACK, 8'h00);
    issue(CMD_GET_REG, IDX_MULTI_CFG, 8'h00, RSP_ACK, 8'h05);
    // Mid-run reset as the second regulator restores all defaults
    do_reset(8'ha5, 1'b1);
    wait_cycles(3);
    issue(CMD_GET_REG, IDX_MULTI_CFG, 8'h00, RSP_ACK, MULTI_CFG_SECOND_RST);
    issue(CMD_GET_REG, IDX_BOOT_VOLTAGE, 8'h00, RSP_ACK, 8'ha5);
    issue(CMD_GET_REG, IDX_MAX_LIMIT, 8'h00, RSP_ACK, MAX_LIMIT_RST);
    issue(CMD_GET_REG, IDX_POWER_STATE, 8'h00, RSP_ACK, 8'h00);
    check("vout boot again", vout_code, 8'ha5);
    summarize();
  end
endmodule
`default_nettype wire
